//--- logic/fault_mask_merge.v
`timescale 1ns/1ns
`include "valve_io_defs.vh"
// Combines fault sources through the four mask registers, with the unmaskable faults added unmasked
module fault_mask_merge (
  input wire [15:0] i_service_one, // Service faults, mask one layout
  input wire [15:0] i_service_two, // Service faults, mask two layout
  input wire [15:0] i_driver_one, // Driver faults, mask one layout
  input wire [15:0] i_driver_two, // Driver faults, mask two layout
  input wire [15:0] i_mask_s1, // service_fault_mask_one
  input wire [15:0] i_mask_s2, // service_fault_mask_two
  input wire [15:0] i_mask_d1, // driver_fault_mask_one
  input wire [15:0] i_mask_d2, // driver_fault_mask_two
  input wire i_enable_low, // Enable pin is low
  input wire [7:0] i_unmaskable, // Faults with no mask bit
  output wire o_any_fault // Some unmasked fault active
);

  wire s1_hit;
  wire s2_hit;
  wire d1_hit;
  wire d2_hit;
  wire en_hit;

  assign s1_hit = |(i_service_one & ~i_mask_s1 & `SERVICE_ONE_MASKABLE);
  assign s2_hit = |(i_service_two & ~i_mask_s2 & `SERVICE_TWO_MASKABLE);
  assign d1_hit = |(i_driver_one & ~i_mask_d1 & `DRIVER_ONE_MASKABLE);
  assign d2_hit = |(i_driver_two & ~i_mask_d2 & `DRIVER_TWO_MASKABLE);
  assign en_hit = i_enable_low & ~i_mask_s2[`ENABLE_MASK_BIT];
  assign o_any_fault = s1_hit | s2_hit | d1_hit | d2_hit | en_hit | (|i_unmaskable);

endmodule

//--- logic/pin_deglitch.v
`timescale 1ns/1ns
// Two-flop synchroniser followed by a stability filter
module pin_deglitch #(
  parameter CW = 8,
  parameter RESET_LEVEL = 1'b0
) (
  input wire i_core_clk, // Core clock
  input wire i_reset, // Synchronous reset, active high
  input wire i_pin, // Asynchronous pin level
  input wire [CW-1:0] i_stable_cycles, // Cycles the level must hold
  output reg o_level // Filtered level
);

  reg sync1_q;
  reg sync2_q;
  reg [CW-1:0] cnt_q;

  always @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      sync1_q <= RESET_LEVEL;
      sync2_q <= RESET_LEVEL;
      cnt_q <= {CW{1'b0}};
      o_level <= RESET_LEVEL;
    end
    else
    begin
      sync1_q <= i_pin;
      sync2_q <= sync1_q;
      if (sync2_q == o_level)
        cnt_q <= {CW{1'b0}};
      else if (cnt_q >= i_stable_cycles - {{(CW-1){1'b0}}, 1'b1})
      begin
        o_level <= sync2_q;
        cnt_q <= {CW{1'b0}};
      end
      else
        cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
    end
  end

endmodule

//--- logic/valve_driver_io_fault_control.v
`timescale 1ns/1ns
`include "valve_io_defs.vh"
module valve_driver_io_fault_control #(
  parameter CHANNELS = 4,
  parameter CW = 8
) (
  input wire i_core_clk, // Core clock, 50 MHz
  input wire i_reset, // Synchronous power-on reset, active high
  input wire i_device_reset_input_low, // Reset pin, active low, asynchronous
  input wire i_output_stage_enable_pin, // Output stage enable pin, asynchronous
  input wire [CHANNELS-1:0] i_channel_control_input, // Channel pins, asynchronous
  input wire [CHANNELS-1:0] i_channel_config_enable, // Channel configured active
  input wire [CHANNELS-1:0] i_software_mode, // 1 software mode, 0 hardware mode
  input wire [CHANNELS-1:0] i_high_side_config, // 1 high side, 0 low side
  input wire [CHANNELS-1:0] i_loop_drive_phase, // Current loop asks drive phase
  input wire i_failsafe_config, // Fail-safe pre-driver request
  input wire i_mask_wr, // Mask register write strobe
  input wire [1:0] i_mask_sel, // Mask register select
  input wire [15:0] i_mask_wdata, // Mask register write data
  input wire [15:0] i_service_one_faults, // Service faults, mask one layout
  input wire [15:0] i_service_two_faults, // Service faults, mask two layout
  input wire [15:0] i_driver_one_faults, // Driver faults, mask one layout
  input wire [15:0] i_driver_two_faults, // Driver faults, mask two layout
  input wire [7:0] i_unmaskable_faults, // Faults with no mask bit
  output reg [15:0] o_mask_rdata, // Selected mask register
  output reg o_reset_echo, // Reset pin level for serial frames
  output reg o_enable_echo, // Filtered enable pin level
  output reg [CHANNELS-1:0] o_regulation_enable, // Hardware loop enable
  output reg [CHANNELS-1:0] o_high_side_on, // High-side transistor gate on
  output reg [CHANNELS-1:0] o_low_side_on, // Low-side transistor gate on
  output reg o_failsafe_enable, // Fail-safe pre-driver enable
  output reg o_fault_flag_output_low, // Fault pin output value
  output reg o_fault_flag_oe // Fault pin pull-down enable
);

  // Minimum filter widths rounded up to whole core cycles
  localparam integer SW_CYCLES_FULL =
    (`SW_DEGLITCH_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam integer HW_CYCLES_FULL =
    (`HW_DEGLITCH_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam [CW-1:0] SW_DEGLITCH_CYCLES = SW_CYCLES_FULL[CW-1:0];
  localparam [CW-1:0] HW_DEGLITCH_CYCLES = HW_CYCLES_FULL[CW-1:0];

  wire reset_pin_level;
  wire enable_level;
  wire [CHANNELS-1:0] ch_level;
  wire any_fault;
  wire device_reset;

  reg [15:0] mask_s1_q;
  reg [15:0] mask_s2_q;
  reg [15:0] mask_d1_q;
  reg [15:0] mask_d2_q;
  reg [15:0] mask_rdata_d;
  reg [CHANNELS-1:0] reg_en_d;
  reg [CHANNELS-1:0] hs_on_d;
  reg [CHANNELS-1:0] ls_on_d;
  reg driving;
  integer k;

  pin_deglitch #(
    .CW(CW),
    .RESET_LEVEL(1'b0)
  ) u_reset_pin (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_pin(i_device_reset_input_low),
    .i_stable_cycles(`PIN_SETTLE_CYCLES),
    .o_level(reset_pin_level)
  );

  assign device_reset = i_reset | ~reset_pin_level;

  pin_deglitch #(
    .CW(CW),
    .RESET_LEVEL(1'b0)
  ) u_enable_pin (
    .i_core_clk(i_core_clk),
    .i_reset(device_reset),
    .i_pin(i_output_stage_enable_pin),
    .i_stable_cycles(`PIN_SETTLE_CYCLES),
    .o_level(enable_level)
  );

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1)
    begin : gen_ch
      pin_deglitch #(
        .CW(CW),
        .RESET_LEVEL(1'b0)
      ) u_ch_pin (
        .i_core_clk(i_core_clk),
        .i_reset(device_reset),
        .i_pin(i_channel_control_input[g]),
        .i_stable_cycles(i_software_mode[g] ? SW_DEGLITCH_CYCLES : HW_DEGLITCH_CYCLES),
        .o_level(ch_level[g])
      );
    end
  endgenerate

  fault_mask_merge u_merge (
    .i_service_one(i_service_one_faults),
    .i_service_two(i_service_two_faults),
    .i_driver_one(i_driver_one_faults),
    .i_driver_two(i_driver_two_faults),
    .i_mask_s1(mask_s1_q),
    .i_mask_s2(mask_s2_q),
    .i_mask_d1(mask_d1_q),
    .i_mask_d2(mask_d2_q),
    .i_enable_low(~enable_level),
    .i_unmaskable(i_unmaskable_faults),
    .o_any_fault(any_fault)
  );

  // masks return to defaults in reset
  always @(posedge i_core_clk)
  begin
    if (device_reset)
    begin
      mask_s1_q <= `MASK_RESET_VALUE;
      mask_s2_q <= `MASK_RESET_VALUE;
      mask_d1_q <= `MASK_RESET_VALUE;
      mask_d2_q <= `MASK_RESET_VALUE;
    end
    else if (i_mask_wr)
    begin
      case (i_mask_sel)
        `SEL_SERVICE_MASK_ONE: mask_s1_q <= i_mask_wdata;
        `SEL_SERVICE_MASK_TWO: mask_s2_q <= i_mask_wdata;
        `SEL_DRIVER_MASK_ONE: mask_d1_q <= i_mask_wdata;
        `SEL_DRIVER_MASK_TWO: mask_d2_q <= i_mask_wdata;
        default: mask_s1_q <= mask_s1_q;
      endcase
    end
  end

  always @*
  begin
    case (i_mask_sel)
      `SEL_SERVICE_MASK_ONE: mask_rdata_d = mask_s1_q;
      `SEL_SERVICE_MASK_TWO: mask_rdata_d = mask_s2_q;
      `SEL_DRIVER_MASK_ONE: mask_rdata_d = mask_d1_q;
      `SEL_DRIVER_MASK_TWO: mask_rdata_d = mask_d2_q;
      default: mask_rdata_d = `MASK_RESET_VALUE;
    endcase
  end

  // Per-channel transistor selection
  always @*
  begin
    reg_en_d = {CHANNELS{1'b0}};
    hs_on_d = {CHANNELS{1'b0}};
    ls_on_d = {CHANNELS{1'b0}};
    driving = 1'b0;
    for (k = 0; k < CHANNELS; k = k + 1)
    begin
      driving = 1'b0;
      if (enable_level && i_channel_config_enable[k])
      begin
        if (i_software_mode[k])
        begin
          driving = ch_level[k];
          hs_on_d[k] = i_high_side_config[k] ? driving : ~driving;
          ls_on_d[k] = i_high_side_config[k] ? ~driving : driving;
        end
        else
        begin
          reg_en_d[k] = ~ch_level[k];
          driving = i_loop_drive_phase[k];
          hs_on_d[k] = reg_en_d[k] & (i_high_side_config[k] ? driving : ~driving);
          ls_on_d[k] = reg_en_d[k] & (i_high_side_config[k] ? ~driving : driving);
        end
      end
    end
  end

  always @(posedge i_core_clk)
  begin
    if (device_reset)
    begin
      o_regulation_enable <= {CHANNELS{1'b0}};
      o_high_side_on <= {CHANNELS{1'b0}};
      o_low_side_on <= {CHANNELS{1'b0}};
      o_failsafe_enable <= 1'b0;
      o_fault_flag_oe <= 1'b1;
      o_enable_echo <= 1'b0;
      o_mask_rdata <= `MASK_RESET_VALUE;
    end
    else
    begin
      o_regulation_enable <= reg_en_d;
      o_high_side_on <= hs_on_d;
      o_low_side_on <= ls_on_d;
      o_failsafe_enable <= enable_level & i_failsafe_config;
      o_fault_flag_oe <= any_fault;
      o_enable_echo <= enable_level;
      o_mask_rdata <= mask_rdata_d;
    end
  end

  always @(posedge i_core_clk)
  begin
    o_fault_flag_output_low <= 1'b0;
  end

  always @(posedge i_core_clk)
  begin
    if (i_reset)
      o_reset_echo <= 1'b0;
    else
      o_reset_echo <= reset_pin_level;
  end

endmodule

//--- logic/valve_io_defs.vh
`ifndef VALVE_IO_DEFS_VH
`define VALVE_IO_DEFS_VH

// Mask register selectors on the internal register port
`define SEL_SERVICE_MASK_ONE 2'h0
`define SEL_SERVICE_MASK_TWO 2'h1
`define SEL_DRIVER_MASK_ONE 2'h2
`define SEL_DRIVER_MASK_TWO 2'h3

// Bits that own a mask; other positions are not maskable and are ignored
`define SERVICE_ONE_MASKABLE 16'hC5DF
`define SERVICE_TWO_MASKABLE 16'h801F
`define DRIVER_ONE_MASKABLE 16'hF07F
`define DRIVER_TWO_MASKABLE 16'h001F

// Mask bit that hides the enable-low condition
`define ENABLE_MASK_BIT 0

`define MASK_RESET_VALUE 16'h0000

// Timing, in nanoseconds
`define CLK_PERIOD_NS 20
`define SW_DEGLITCH_MIN_NS 3000
`define HW_DEGLITCH_MIN_NS 1200
// Pins other than channel inputs settle after one stable cycle
`define PIN_SETTLE_CYCLES 8'h01

`endif

//--- test/host_pullup.sv
`timescale 1ns/1ns
module host_pullup (
  input wire i_fault_drive, // Value offered on the pin
  input wire i_fault_oe, // Device pulls the pin
  output wire o_fault_line // Resolved pin level
);
  assign o_fault_line = i_fault_oe ? i_fault_drive : 1'b1;
endmodule

//--- test/tb_top.sv
`timescale 1ns/1ns
`include "valve_io_defs.vh"
`define CHK(n, e, a) begin n_tests = n_tests + 1; if ((a) !== (e)) begin \
  err_total = err_total + 1; $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module tb_top;
  reg clk = 1'b0, rst = 1'b1, rpin = 1'b1, en = 1'b1, fscfg = 1'b0, wr = 1'b0;
  reg [3:0] ctl = 4'h0, cfgen = 4'h7, sw = 4'hF, hs = 4'h5, ph = 4'hA;
  reg [1:0] sel = 2'h0;
  reg [7:0] fix = 8'h00;
  reg [15:0] wd = 16'h0000;
  reg [15:0] f [0:3];
  reg [15:0] mk [0:3];
  wire recho, eecho, fs_on, fdrv, foe, fline;
  wire [3:0] reg_en, hs_on, ls_on;
  wire [15:0] rdata;
  integer err_total = 0, n_tests = 0, g, b;
  always #10 clk = ~clk;
  valve_driver_io_fault_control DUT (.i_core_clk(clk), .i_reset(rst),
    .i_device_reset_input_low(rpin), .i_output_stage_enable_pin(en),
    .i_channel_control_input(ctl), .i_channel_config_enable(cfgen), .i_software_mode(sw),
    .i_high_side_config(hs), .i_loop_drive_phase(ph), .i_failsafe_config(fscfg),
    .i_mask_wr(wr), .i_mask_sel(sel), .i_mask_wdata(wd), .i_service_one_faults(f[0]),
    .i_service_two_faults(f[1]), .i_driver_one_faults(f[2]), .i_driver_two_faults(f[3]),
    .i_unmaskable_faults(fix), .o_mask_rdata(rdata), .o_reset_echo(recho),
    .o_enable_echo(eecho), .o_regulation_enable(reg_en), .o_high_side_on(hs_on),
    .o_low_side_on(ls_on), .o_failsafe_enable(fs_on), .o_fault_flag_output_low(fdrv),
    .o_fault_flag_oe(foe));
  host_pullup host (.i_fault_drive(fdrv), .i_fault_oe(foe), .o_fault_line(fline));
  task finish_test;
  begin
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  task step(input integer n);
  begin
    repeat (n) @(posedge clk);
    #1;
  end
  endtask
  task wr_mask(input [1:0] s, input [15:0] d);
  begin
    sel = s;
    wd = d;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    step(2);
  end
  endtask
  // Bounded wait for the pin to be released
  task wait_clean;
    integer i;
  begin
    for (i = 0; i < 60 && fline !== 1'b1; i = i + 1)
      step(1);
    `CHK("fault release", 1'b1, fline)
    if (fline !== 1'b1)
      finish_test;
  end
  endtask
  task t_masks;
  begin
    for (g = 0; g < 4; g = g + 1)
    begin
      wr_mask(g[1:0], mk[g]);
      `CHK("mask readback", mk[g], rdata)
    end
    for (b = 0; b < 136; b = b + 1)
    begin
      if (b == 64)
        for (g = 0; g < 4; g = g + 1)
          wr_mask(g[1:0], 16'h0000);
      if (b < 128)
        f[b[5:4]] = 16'h0001 << b[3:0];
      else
        fix = 8'h01 << b[2:0];
      step(2);
      `CHK("fault pin", b < 64 || (b < 128 && !mk[b[5:4]][b[3:0]]), fline)
      f[b[5:4]] = 16'h0000;
      fix = 8'h00;
      step(1);
    end
  end
  endtask
  task t_enable;
  begin
    `CHK("failsafe off", 1'b0, fs_on)
    fscfg = 1'b1;
    step(10);
    `CHK("failsafe on", 1'b1, fs_on)
    `CHK("enable echo high", 1'b1, eecho)
    en = 1'b0;
    step(12);
    `CHK("stage off", 13'h0000, {reg_en, hs_on, ls_on, fs_on})
    `CHK("enable echo low", 1'b0, eecho)
    `CHK("enable fault", 1'b0, fline)
    wr_mask(2'h1, 16'h0001);
    `CHK("enable masked", 1'b1, fline)
    en = 1'b1;
  end
  endtask
  task t_channels;
  begin
    step(210);
    `CHK("sw low", {~hs & cfgen, hs & cfgen}, {hs_on, ls_on})
    ctl = 4'hF;
    step(140);
    ctl = 4'h0;
    step(10);
    `CHK("sw glitch", {~hs & cfgen, hs & cfgen}, {hs_on, ls_on})
    ctl = 4'hF;
    step(210);
    `CHK("sw high", {hs & cfgen, ~hs & cfgen}, {hs_on, ls_on})
    sw = 4'h0;
    ctl = 4'h0;
    step(110);
    `CHK("hw enabled", cfgen, reg_en)
    `CHK("hw recirc phase", {4'h0, cfgen}, {hs_on, ls_on})
    ph = 4'h5;
    step(2);
    `CHK("hw drive phase", {cfgen, 4'h0}, {hs_on, ls_on})
    ctl = 4'hF;
    step(55);
    ctl = 4'h0;
    step(10);
    `CHK("hw glitch", cfgen, reg_en)
    ctl = 4'hF;
    step(110);
    `CHK("hw disabled", 4'h0, reg_en)
    `CHK("hw gates off", 8'h00, {hs_on, ls_on})
  end
  endtask
  task t_pin_reset;
  begin
    rpin = 1'b0;
    step(10);
    `CHK("pin reset fault", 1'b0, fline)
    `CHK("pin reset echo", 1'b0, recho)
    `CHK("pin reset drive", 13'h0000, {reg_en, hs_on, ls_on, fs_on})
    rpin = 1'b1;
    wait_clean;
    sel = 2'h1;
    step(2);
    `CHK("mask default", 16'h0000, rdata)
  end
  endtask
  initial
  begin
    mk[0] = `SERVICE_ONE_MASKABLE;
    mk[1] = `SERVICE_TWO_MASKABLE;
    mk[2] = `DRIVER_ONE_MASKABLE;
    mk[3] = `DRIVER_TWO_MASKABLE;
    for (g = 0; g < 4; g = g + 1)
      f[g] = 16'h0000;
    step(8);
    `CHK("reset fault", 1'b0, fline)
    `CHK("reset masks", 16'h0000, rdata)
    `CHK("reset drive", 13'h0000, {reg_en, hs_on, ls_on, fs_on})
    rst = 1'b0;
    wait_clean;
    `CHK("reset echo", 1'b1, recho)
    t_masks;
    t_enable;
    t_channels;
    t_pin_reset;
    finish_test;
  end
endmodule

//--- test/valve_io_monitor.sv
`timescale 1ns/1ns
module valve_io_monitor #(
  parameter CHANNELS = 4
) (
  input wire i_core_clk, // Clock
  input wire i_reset, // Reset
  input wire i_device_reset_input_low, // Reset pin
  input wire i_output_stage_enable_pin, // Enable pin
  input wire [CHANNELS-1:0] i_channel_control_input, // Channel pins
  input wire [CHANNELS-1:0] i_channel_config_enable, // Active channels
  input wire [CHANNELS-1:0] i_software_mode, // Mode
  input wire [CHANNELS-1:0] i_high_side_config, // Side
  input wire [7:0] i_unmaskable_faults, // Fixed faults
  input wire o_reset_echo, // Pin echo
  input wire [CHANNELS-1:0] o_regulation_enable, // Loop enable
  input wire [CHANNELS-1:0] o_high_side_on, // High gate
  input wire [CHANNELS-1:0] o_low_side_on, // Low gate
  input wire o_failsafe_enable, // Fail-safe
  input wire o_fault_flag_output_low, // Pin value
  input wire o_fault_flag_oe // Pin pull
);
  wire [5:0] set_d = {i_channel_control_input[0], i_software_mode[0], i_high_side_config[0],
    i_channel_config_enable[0], i_output_stage_enable_pin, i_device_reset_input_low};
  wire drv_off = ~|{o_regulation_enable, o_high_side_on, o_low_side_on, o_failsafe_enable};
  wire ch0_live = i_channel_config_enable[0] & i_output_stage_enable_pin;
  wire sw_in = i_channel_control_input[0];
  reg [5:0] set_q;
  reg [7:0] held_q;
  // Cycles that channel 0 settings and both pins have held
  always @(posedge i_core_clk)
  begin
    set_q <= set_d;
    if (i_reset || set_d != set_q)
      held_q <= 8'h00;
    else if (held_q != 8'hFF)
      held_q <= held_q + 8'h01;
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);
  a_reset_forces_off: assert property (disable iff (1'b0) i_reset |=>
    o_fault_flag_oe && drv_off && !o_reset_echo) else $error("Outputs live in reset");
  a_no_high_drive: assert property (o_fault_flag_output_low == 1'b0)
    else $error("Fault pin driven high");
  a_pin_reset_holds: assert property (!i_device_reset_input_low [*8] |->
    o_fault_flag_oe && drv_off) else $error("Reset pin low ignored");
  a_enable_low_off: assert property (!i_output_stage_enable_pin [*8] |-> drv_off)
    else $error("Stage live with enable low");
  a_fixed_fault_pull: assert property (|i_unmaskable_faults |=> o_fault_flag_oe)
    else $error("Unmaskable fault not on pin");
  a_clean_release: assert property (!o_fault_flag_oe |-> o_reset_echo &&
    $past(i_unmaskable_faults) == 8'h00) else $error("Fault pin released early");
  a_sw_drive_side: assert property (held_q == 8'hC8 && i_software_mode[0] && ch0_live |->
    o_high_side_on[0] == (sw_in == i_high_side_config[0]) &&
    o_low_side_on[0] == (sw_in != i_high_side_config[0])) else $error("Software drive wrong");
  a_hw_input_enable: assert property (held_q == 8'h64 && !i_software_mode[0] && ch0_live |->
    o_regulation_enable[0] == !sw_in) else $error("Hardware enable wrong");
  c_sw_drive: cover property (held_q == 8'hC8 && i_software_mode[0] && sw_in);
  c_hw_disable: cover property (held_q == 8'h64 && !i_software_mode[0] && sw_in);
  c_fixed_fault: cover property (|i_unmaskable_faults);
endmodule
bind valve_driver_io_fault_control valve_io_monitor #(.CHANNELS(CHANNELS)) mon (.*);
